// ===== sra_device.sv
`timescale 1ns/100ps
// Contract
// - write frames start with flag zero
// - shift serial_in on each selected rising sclk
// - select low for whole transaction
// - ignore sclk while select high
// - unaddressed devices kept deselected by host
// - mode 3 needs extra half period
// - read frames start with flag one
// - readback low during address part
// - readback updated after falling sclk
// - ignore serial_in during read data
// - sample sync inputs on reference rising
module sra_device (
  input  wire logic mclk,
  input  wire logic rst,
  sra_link_if.device link,
  input  wire logic reference_clock_in,
  input  wire logic sync_in,
  input  wire logic ref_request_in,
  output logic      sync_sampled,
  output logic      ref_request_sampled,
  output logic      write_strobe,
  output logic [6:0]  write_addr,
  output logic [15:0] write_data
);
  logic [2:0] sclk_s, sel_s, sdi_s, refc_s;
  logic [1:0] sync_s, rreq_s;
  logic [sra_pkg::DATA_BITS-1:0] regs [sra_pkg::REG_COUNT];
  logic [sra_pkg::FRAME_BITS-1:0] shift_reg, shift_next;
  logic [sra_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [sra_pkg::DATA_BITS-1:0] rd_reg, rd_next;
  logic rb_reg, rb_next, rw_reg, rw_next;
  logic we_reg, we_next, syn_reg, syn_next, rq_reg, rq_next;
  logic [sra_pkg::ADDR_BITS-1:0] wa_reg, wa_next;
  logic [sra_pkg::DATA_BITS-1:0] wd_reg, wd_next;
  logic sclk_rise, sclk_fall, sel_rise, refc_rise, selected;

  // bit 0 of each stage-set feeds only bit 1; edges use bits 1 and 2
  always_ff @(posedge mclk) begin
    sclk_s <= {sclk_s[1:0], link.sclk};
    sel_s  <= {sel_s[1:0], link.select_n};
    sdi_s  <= {sdi_s[1:0], link.serial_in};
    refc_s <= {refc_s[1:0], reference_clock_in};
    sync_s <= {sync_s[0], sync_in};
    rreq_s <= {rreq_s[0], ref_request_in};
  end

  always_comb begin
    selected  = !sel_s[1];
    sclk_rise = sclk_s[1] && !sclk_s[2] && selected;
    sclk_fall = !sclk_s[1] && sclk_s[2] && selected;
    sel_rise  = sel_s[1] && !sel_s[2];
    refc_rise = refc_s[1] && !refc_s[2];
  end

  always_comb begin
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    rd_next    = rd_reg;
    rb_next    = rb_reg;
    rw_next    = rw_reg;
    we_next    = 1'b0;
    wa_next    = wa_reg;
    wd_next    = wd_reg;
    syn_next   = syn_reg;
    rq_next    = rq_reg;
    if (refc_rise) begin
      syn_next = sync_s[1];
      rq_next  = rreq_s[1];
    end
    if (!selected) begin
      cnt_next = '0;
      rb_next  = 1'b0;
    end
    if (sclk_rise && cnt_reg < sra_pkg::CNT_FRAME) begin
      // read data phase: serial_in not taken
      if (!(rw_reg == sra_pkg::RW_READ && cnt_reg >= sra_pkg::CNT_ADDR_END)) begin
        shift_next = {shift_reg[sra_pkg::FRAME_BITS-2:0], sdi_s[1]};
      end
      if (cnt_reg == '0) begin
        rw_next = sdi_s[1];
      end
      if (cnt_reg == sra_pkg::CNT_ADDR_END - 5'h01 && rw_reg == sra_pkg::RW_READ) begin
        rd_next = regs[{shift_reg[sra_pkg::ADDR_BITS-2:0], sdi_s[1]}];
      end
      cnt_next = cnt_reg + 5'h01;
    end
    if (sclk_fall && rw_reg == sra_pkg::RW_READ) begin
      if (cnt_reg >= sra_pkg::CNT_ADDR_END && cnt_reg < sra_pkg::CNT_FRAME) begin
        rb_next = rd_reg[sra_pkg::DATA_BITS-1];
        rd_next = {rd_reg[sra_pkg::DATA_BITS-2:0], 1'b0};
      end else begin
        rb_next = 1'b0;
      end
    end
    if (sel_rise && cnt_reg == sra_pkg::CNT_FRAME && rw_reg == sra_pkg::RW_WRITE) begin
      we_next = 1'b1;
      wa_next = shift_reg[sra_pkg::FRAME_BITS-2 -: sra_pkg::ADDR_BITS];
      wd_next = shift_reg[sra_pkg::DATA_BITS-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_reg <= '0;
      cnt_reg   <= '0;
      rd_reg    <= '0;
      rb_reg    <= 1'b0;
      rw_reg    <= sra_pkg::RW_WRITE;
      we_reg    <= 1'b0;
      wa_reg    <= '0;
      wd_reg    <= '0;
      syn_reg   <= 1'b0;
      rq_reg    <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      rd_reg    <= rd_next;
      rb_reg    <= rb_next;
      rw_reg    <= rw_next;
      we_reg    <= we_next;
      wa_reg    <= wa_next;
      wd_reg    <= wd_next;
      syn_reg   <= syn_next;
      rq_reg    <= rq_next;
    end
  end

  // register array: no reset, contents held in a plain memory
  always_ff @(posedge mclk) begin
    if (we_next) begin
      regs[wa_next] <= wd_next;
    end
  end

  assign link.readback_out   = rb_reg;
  assign write_strobe        = we_reg;
  assign write_addr          = wa_reg;
  assign write_data          = wd_reg;
  assign sync_sampled        = syn_reg;
  assign ref_request_sampled = rq_reg;
endmodule : sra_device

// ===== sra_host.sv
`timescale 1ns/100ps
module sra_host (
  input  wire logic mclk,
  input  wire logic rst,
  sra_link_if.host  link,
  input  wire logic start,
  input  wire logic read,
  input  wire logic [6:0]  addr,
  input  wire logic [15:0] wdata,
  output logic      busy,
  output logic      done,
  output logic [15:0] rdata
);
  sra_pkg::sra_host_state_t st_reg, st_next;
  logic [sra_pkg::DIV_W-1:0] div_reg, div_next;
  logic [sra_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [sra_pkg::FRAME_BITS-1:0] sh_reg, sh_next;
  logic [sra_pkg::DATA_BITS-1:0] rd_reg, rd_next;
  logic sclk_reg, sclk_next, sel_reg, sel_next, done_reg, done_next;
  logic busy_reg, busy_next;
  logic [1:0] rb_s;
  logic tick;

  always_ff @(posedge mclk) begin
    rb_s <= {rb_s[0], link.readback_out};
  end

  always_comb begin
    tick = (div_reg == sra_pkg::DIV_W'(sra_pkg::SCLK_HALF_CYC - 1));
  end

  // mode 0 framing; sclk low at select edges so no extra half period is needed
  always_comb begin
    st_next   = st_reg;
    div_next  = tick ? '0 : div_reg + 6'h01;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    rd_next   = rd_reg;
    sclk_next = sclk_reg;
    sel_next  = sel_reg;
    done_next = 1'b0;
    unique case (st_reg)
      sra_pkg::SRA_IDLE: begin
        sel_next = 1'b1;
        if (start) begin
          sh_next  = {read ? sra_pkg::RW_READ : sra_pkg::RW_WRITE, addr, wdata};
          sel_next = 1'b0;
          cnt_next = '0;
          div_next = '0;
          st_next  = sra_pkg::SRA_SHIFT;
        end
      end
      sra_pkg::SRA_SHIFT: begin
        if (tick) begin
          if (!sclk_reg) begin
            sclk_next = 1'b1;
            rd_next   = {rd_reg[sra_pkg::DATA_BITS-2:0], rb_s[1]};
          end else begin
            sclk_next = 1'b0;
            sh_next   = {sh_reg[sra_pkg::FRAME_BITS-2:0], 1'b0};
            cnt_next  = cnt_reg + 5'h01;
            if (cnt_reg == sra_pkg::CNT_FRAME - 5'h01) begin
              st_next = sra_pkg::SRA_GAP;
            end
          end
        end
      end
      sra_pkg::SRA_GAP: begin
        // one half period after the last fall covers the select tail
        if (tick) begin
          sel_next = 1'b1;
          st_next  = sra_pkg::SRA_END;
        end
      end
      sra_pkg::SRA_END: begin
        if (tick) begin
          done_next = 1'b1;
          st_next   = sra_pkg::SRA_IDLE;
        end
      end
    endcase
    busy_next = (st_next != sra_pkg::SRA_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg   <= sra_pkg::SRA_IDLE;
      div_reg  <= '0;
      cnt_reg  <= '0;
      sh_reg   <= '0;
      rd_reg   <= '0;
      sclk_reg <= 1'b0;
      sel_reg  <= 1'b1;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      div_reg  <= div_next;
      cnt_reg  <= cnt_next;
      sh_reg   <= sh_next;
      rd_reg   <= rd_next;
      sclk_reg <= sclk_next;
      sel_reg  <= sel_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
    end
  end

  assign link.sclk      = sclk_reg;
  assign link.select_n  = sel_reg;
  assign link.serial_in = sh_reg[sra_pkg::FRAME_BITS-1];
  assign busy           = busy_reg;
  assign done           = done_reg;
  assign rdata          = rd_reg;
endmodule : sra_host

// ===== sra_link_if.sv
`timescale 1ns/100ps
interface sra_link_if;
  logic sclk;
  logic select_n;
  logic serial_in;
  logic readback_out;
  modport device (input sclk, input select_n, input serial_in, output readback_out);
  modport host   (output sclk, output select_n, output serial_in, input readback_out);
endinterface : sra_link_if

// ===== sra_link_monitor.sv
`timescale 1ns/100ps
module sra_link_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic readback_out
);
  logic       sclk_reg;
  logic       sclk_next;
  logic [4:0] rise_reg;
  logic [4:0] rise_next;
  logic [5:0] age_reg;
  logic [5:0] age_next;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // age saturates so a long idle never wraps into a false recent fall
  always_comb begin
    sclk_next = sclk;
    rise_next = select_n ? 5'h00 : rise_reg + {4'h0, sclk & ~sclk_reg};
    age_next  = (sclk_reg & ~sclk) ? 6'h00 : age_reg + {5'h00, age_reg != 6'h3F};
  end
  always_ff @(posedge mclk) begin
    sclk_reg <= rst ? 1'b0 : sclk_next;
    rise_reg <= rst ? 5'h00 : rise_next;
    age_reg  <= rst ? 6'h3F : age_next;
  end
  idle_clock_a: assert property (select_n |-> !sclk)
    else $error("serial clock active while deselected");
  addr_low_a: assert property (!select_n && rise_reg < 5'h08 |-> !readback_out)
    else $error("readback high during address part");
  update_after_fall_a: assert property (!select_n && $changed(readback_out) |-> age_reg <= 6'h06)
    else $error("readback changed away from a falling clock");
  clock_half_a: assert property ($changed(sclk) |=> $stable(sclk) [*8])
    else $error("serial clock half period too short");
  select_lead_a: assert property ($fell(select_n) |-> !sclk [*8])
    else $error("clock moved too soon after select");
  frame_count_a: assert property ($rose(select_n) |-> rise_reg == 5'h18)
    else $error("frame not 24 clock rises");
  select_tail_a: assert property ($rose(select_n) |-> age_reg >= 6'h10)
    else $error("select released too soon after last clock");
  data_stable_a: assert property ($rose(sclk) && !select_n |-> $stable(serial_in) ##1 $stable(serial_in))
    else $error("serial data moved at clock rise");
endmodule : sra_link_monitor

// ===== sra_pkg.sv
package sra_pkg;
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS  = 7;
  localparam int DATA_BITS  = 16;
  localparam int REG_COUNT  = 128;
  localparam int CNT_W      = 5;
  localparam logic [CNT_W-1:0] CNT_ADDR_END = 5'h08;
  localparam logic [CNT_W-1:0] CNT_FRAME    = 5'h18;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ  = 1'b1;
  localparam int MCLK_PERIOD_NS = 4;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam int DIV_W          = 6;
  localparam logic [DATA_BITS-1:0] REG_RESET = 16'h0000;
  typedef enum logic [1:0] {
    SRA_IDLE  = 2'b00,
    SRA_SHIFT = 2'b01,
    SRA_GAP   = 2'b11,
    SRA_END   = 2'b10
  } sra_host_state_t;
endpackage : sra_pkg

// ===== tb.sv
`timescale 1ns/100ps
module tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        reference_clock_in = 1'b0;
  logic        sync_in = 1'b0;
  logic        ref_request_in = 1'b0;
  logic        start = 1'b0;
  logic        read = 1'b0;
  logic [6:0]  addr = 7'h00;
  logic [15:0] wdata = 16'h0000;
  logic        sync_sampled, ref_request_sampled, write_strobe, busy, done;
  logic [6:0]  write_addr, seen_a, a;
  logic [15:0] write_data, rdata, seen_d, d;
  logic [23:0] frame;
  logic [15:0] mem [128];
  logic [31:0] r = 32'h982EF405;
  logic        rd;
  logic [6:0]  wq[$];
  int          n_errors = 0;
  int          tests_run = 0;
  int          n_str = 0;
  int          n0;
  sra_link_if sra_link_if_inst ();
  sra_device sra_device_inst (.mclk(mclk), .rst(rst), .link(sra_link_if_inst.device),
    .reference_clock_in(reference_clock_in), .sync_in(sync_in), .ref_request_in(ref_request_in),
    .sync_sampled(sync_sampled), .ref_request_sampled(ref_request_sampled),
    .write_strobe(write_strobe), .write_addr(write_addr), .write_data(write_data));
  sra_host sra_host_inst (.mclk(mclk), .rst(rst), .link(sra_link_if_inst.host), .start(start),
    .read(read), .addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
  sra_link_monitor sra_link_monitor_inst (.mclk(mclk), .rst(rst), .sclk(sra_link_if_inst.sclk),
    .select_n(sra_link_if_inst.select_n), .serial_in(sra_link_if_inst.serial_in),
    .readback_out(sra_link_if_inst.readback_out));
  always #2 mclk = ~mclk;
  // reference period is 3.5 mclk periods so the sampler sees rises at two alternating mclk phases
  always #7 reference_clock_in = ~reference_clock_in;
  always @(posedge sra_link_if_inst.sclk) if (!sra_link_if_inst.select_n) begin
    frame = {frame[22:0], sra_link_if_inst.serial_in};
  end
  always @(posedge mclk) if (write_strobe === 1'b1) begin
    seen_a <= write_addr;
    seen_d <= write_data;
    n_str <= n_str + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [23:0] frame_exp(input logic f, input logic [6:0] x, input logic [15:0] y);
    return {f, x, y};
  endfunction : frame_exp
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic xfer(input logic f, input logic [6:0] x, input logic [15:0] y);
    int k;
    @(negedge mclk);
    start = 1'b1;
    read = f;
    addr = x;
    wdata = y;
    @(negedge mclk);
    start = 1'b0;
    k = 0;
    chk(24'(busy), 24'h1);
    while (done !== 1'b1 && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 2000) begin
      n_errors++;
      end_sim();
    end
    chk(24'(busy), 24'h0);
  endtask : xfer
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 24; i++) begin
      r = xs(r);
      rd = (i == 2 || i == 3) || (i > 3 && r[0]);
      a = (i < 4) ? {7{~i[0]}} : (rd ? wq[r[9:4] % wq.size()] : r[14:8]);
      d = (i < 2) ? {16{~i[0]}} : r[31:16];
      sync_in = r[1];
      ref_request_in = r[2];
      n0 = n_str;
      xfer(rd, a, d);
      if (rd) begin
        chk(frame[23:16], frame_exp(1'b1, a, 16'h0000) >> 16);
        chk(rdata, mem[a]);
        chk(24'(n_str - n0), 24'h0);
      end else begin
        chk(frame, frame_exp(1'b0, a, d));
        chk(24'(n_str - n0), 24'h1);
        chk({seen_a, seen_d}, {1'b0, a, d});
        mem[a] = d;
        wq.push_back(a);
      end
      chk({sync_sampled, ref_request_sampled}, r[2:1] == 2'b01 ? 2'b10 : {r[1], r[2]});
      $display("test %0d finished", i);
    end
    end_sim();
  end
  initial begin
    #300000;
    n_errors++;
    end_sim();
  end
endmodule : tb
